/* File: ppio_pkg.sv */
/*
 Constants for the programmable parallel I/O block: address codes,
 configuration word fields, reset values and strobe filter sizes.
 Assumes a single 10 MHz system clock.
*/
package ppio_pkg;
   // Port select address codes
   localparam logic [1:0] ADDR_FIRST  = 2'h0;
   localparam logic [1:0] ADDR_SECOND = 2'h1;
   localparam logic [1:0] ADDR_SPLIT  = 2'h2;
   localparam logic [1:0] ADDR_CONFIG = 2'h3;
   // Configuration word fields
   localparam int CFG_MODESET_BIT   = 7;
   localparam int CFG_A_MODE_HI     = 6;
   localparam int CFG_A_MODE_LO     = 5;
   localparam int CFG_FIRST_IN_BIT  = 4;
   localparam int CFG_SPLIT_HI_BIT  = 3;
   localparam int CFG_B_MODE_BIT    = 2;
   localparam int CFG_SECOND_IN_BIT = 1;
   localparam int CFG_SPLIT_LO_BIT  = 0;
   // Bit set/reset command fields
   localparam int BSR_VALUE_BIT     = 0;
   localparam int BSR_SEL_LO        = 1;
   localparam int BSR_SEL_HI        = 3;
   // Reset values: all inputs, latches clear
   localparam logic [7:0] CFG_RESET   = 8'h9b;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   // Group A mode codes
   localparam logic [1:0] MODE_BASIC  = 2'h0;
   localparam logic [1:0] MODE_STROBE = 2'h1;
   // Strobe sampler depth
   localparam int SYNC_STAGES = 2;
endpackage

/* File: ppio_strobe_sync.sv */
/*
 Strobe synchroniser and edge detector for the host strobes.
 Assumes active-low strobes that may arrive asynchronously.
*/
`timescale 1ns/1ns
module ppio_strobe_sync
   import ppio_pkg::*;
(
   input  wire logic clk,
   input  wire logic srst,
   input  wire logic strobe_n,
   output logic      active,
   output logic      rise
);
   logic [SYNC_STAGES-1:0] sync_chain;
   logic                   prev;

   // Second stage feeds the level output and edge logic; first stage feeds the second
   always_ff @(posedge clk) begin
      if (srst) begin
         sync_chain <= '1;
         prev       <= 1'b1;
      end else begin
         sync_chain <= {sync_chain[SYNC_STAGES-2:0], strobe_n};
         prev       <= sync_chain[SYNC_STAGES-1];
      end
   end

   assign active = ~sync_chain[SYNC_STAGES-1];
   assign rise   = sync_chain[SYNC_STAGES-1] & ~prev;
endmodule

/* File: ppio_core.sv */
/*
 Programmable parallel I/O core: three 8-bit ports, host register
 access, mode setting and single-bit set/reset on the split port.
 Assumes host strobes are asynchronous and the pins are resolved
 outside from the output and enable signals given here.
*/
// Overview of operation
// - Eight-bit three-state host data bus
// - Reset clears state, all ports input
// - Chip select high floats bus, ignores access
// - Read strobe drives selected port data
// - Write strobe captures bus into target
// - Two address bits pick one target
// - Config sets port directions; mode 2 bidirectional, yet first port is driven at all times
// - Single split-port bit set or cleared
// - Two twelve-bit groups A and B
// - Modes 0,1 both groups; 2 group A
// - Modes 1,2 claim split lines as control
// - First port: output latch, input latch
// - Second port: shared latch, input buffer
// - Split port input unlatched, live pins
// - Address 00,01,10 ports; 11 config write
// - Mode word bits select port inputs
// - Mode write clears first, split latches
// - Outputs latched, inputs unlatched except first port in modes 1,2
`timescale 1ns/1ns
module ppio_core
   import ppio_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic       chip_sel_n,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   input  wire logic [1:0] port_select_addr,
   input  wire logic [7:0] host_data_in,
   output logic      [7:0] host_data_out,
   output logic            host_data_oe,
   input  wire logic [7:0] port_first_in,
   output logic      [7:0] port_first_out,
   output logic      [7:0] port_first_oe,
   input  wire logic [7:0] port_second_in,
   output logic      [7:0] port_second_out,
   output logic      [7:0] port_second_oe,
   input  wire logic [7:0] port_split_in,
   output logic      [7:0] port_split_out,
   output logic      [7:0] port_split_oe,
   output logic      [1:0] group_a_mode,
   output logic            group_b_mode
);
   logic [7:0] cfg;
   logic [7:0] first_latch;
   logic [7:0] first_in_latch;
   logic [7:0] second_latch;
   logic [7:0] split_latch;
   logic [1:0] addr_hold;
   logic [7:0] data_hold;

   logic rd_active;
   logic wr_active;
   logic wr_rise;
   logic cs_active;
   logic cs_rise;

   ppio_strobe_sync u_rd (
      .clk      (clk),
      .srst     (srst),
      .strobe_n (rd_n),
      .active   (rd_active),
      .rise     ()
   );
   ppio_strobe_sync u_wr (
      .clk      (clk),
      .srst     (srst),
      .strobe_n (wr_n),
      .active   (wr_active),
      .rise     (wr_rise)
   );
   ppio_strobe_sync u_cs (
      .clk      (clk),
      .srst     (srst),
      .strobe_n (chip_sel_n),
      .active   (cs_active),
      .rise     (cs_rise)
   );

   // Address and data held while the write strobe is low, since
   // the bus may change at the same instant the strobe rises
   logic [1:0] wr_addr;
   assign wr_addr = addr_hold[1:0];

   wire [1:0] mode_a      = cfg[CFG_A_MODE_HI:CFG_A_MODE_LO];
   wire       mode_b      = cfg[CFG_B_MODE_BIT];
   wire       a_bidir     = mode_a[1];
   wire       a_strobed   = mode_a != MODE_BASIC;
   // direction fields, set bit means input
   wire       first_is_in = cfg[CFG_FIRST_IN_BIT];
   wire       second_is_in = cfg[CFG_SECOND_IN_BIT];
   wire       split_hi_in = cfg[CFG_SPLIT_HI_BIT];
   wire       split_lo_in = cfg[CFG_SPLIT_LO_BIT];

   // split lines claimed by handshake groups
   wire [7:0] split_ctrl_mask = {(a_bidir ? 5'h1f : (a_strobed ? 5'h0e :
                                  5'h00)), (mode_b ? 3'h7 : 3'h0)};

   // per-half direction, control lines become neither data dir
   wire [7:0] split_dir_out = {{4{~split_hi_in}}, {4{~split_lo_in}}};
   wire [7:0] split_data_out = split_dir_out & ~split_ctrl_mask;

   function automatic logic [7:0] mix_read(input logic [7:0] latch_v,
                                           input logic [7:0] pin_v,
                                           input logic [7:0] out_mask);
      // output lines read their latch; inputs live
      mix_read = (latch_v & out_mask) | (pin_v & ~out_mask);
   endfunction

   // first port reads input latch in strobed modes
   wire [7:0] first_pin_view = a_strobed ? first_in_latch : port_first_in;
   wire [7:0] first_rd = mix_read(first_latch, first_pin_view,
                                  {8{~first_is_in & ~a_bidir}});
   // second port: shared latch, buffer on input
   wire [7:0] second_rd = mix_read(second_latch, port_second_in,
                                   {8{~second_is_in}});
   // split port reads live pins on inputs
   wire [7:0] split_rd = mix_read(split_latch, port_split_in,
                                  split_data_out);

   // read decode; address 11 reads as zero
   wire [7:0] rd_value = (port_select_addr == ADDR_FIRST)  ? first_rd  :
                         (port_select_addr == ADDR_SECOND) ? second_rd :
                         (port_select_addr == ADDR_SPLIT)  ? split_rd  :
                         8'h00;

   // write only with chip select low at the strobe edge
   wire wr_take   = wr_rise & cs_active;
   wire is_config = wr_take & (wr_addr == ADDR_CONFIG);
   wire modeset   = is_config & data_hold[CFG_MODESET_BIT];
   wire bsr       = is_config & ~data_hold[CFG_MODESET_BIT];
   wire [2:0] bsr_sel = data_hold[BSR_SEL_HI:BSR_SEL_LO];

   logic [7:0] bsr_mask;
   assign bsr_mask = 8'h01 << bsr_sel;

   wire [7:0] next_split_bsr = data_hold[BSR_VALUE_BIT] ?
                               (split_latch | bsr_mask) :
                               (split_latch & ~bsr_mask);

   // capture bus while write strobe is low
   always_ff @(posedge clk) begin
      if (srst) begin
         addr_hold <= ADDR_FIRST;
         data_hold <= LATCH_RESET;
      end else if (wr_active) begin
         addr_hold <= port_select_addr;
         data_hold <= host_data_in;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg          <= CFG_RESET;
         first_latch  <= LATCH_RESET;
         second_latch <= LATCH_RESET;
         split_latch  <= LATCH_RESET;
      end else if (modeset) begin
         cfg         <= data_hold;
         first_latch <= LATCH_RESET;
         split_latch <= LATCH_RESET;
      end else if (bsr) begin
         split_latch <= next_split_bsr;
      end else if (wr_take & (wr_addr == ADDR_FIRST)) begin
         first_latch <= data_hold;
      end else if (wr_take & (wr_addr == ADDR_SECOND)) begin
         second_latch <= data_hold;
      end else if (wr_take & (wr_addr == ADDR_SPLIT)) begin
         split_latch <= data_hold;
      end
   end

   // first port input latch follows pins while read is idle, holds during read
   always_ff @(posedge clk) begin
      if (srst) begin
         first_in_latch <= LATCH_RESET;
      end else if (~rd_active) begin
         first_in_latch <= port_first_in;
      end
   end

   // bus drive; cs_rise drops drive at once
   always_ff @(posedge clk) begin
      if (srst) begin
         host_data_out <= LATCH_RESET;
         host_data_oe  <= 1'b0;
      end else begin
         host_data_out <= rd_value;
         host_data_oe  <= rd_active & cs_active & ~cs_rise &
                          (port_select_addr != ADDR_CONFIG);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         port_first_out  <= LATCH_RESET;
         port_first_oe   <= 8'h00;
         port_second_out <= LATCH_RESET;
         port_second_oe  <= 8'h00;
         port_split_out  <= LATCH_RESET;
         port_split_oe   <= 8'h00;
         group_a_mode    <= MODE_BASIC;
         group_b_mode    <= 1'b0;
      end else begin
         port_first_out  <= first_latch;
         // mode 2 drives the first port at all times, host reads or not
         port_first_oe   <= {8{a_bidir | ~first_is_in}};
         port_second_out <= second_latch;
         port_second_oe  <= {8{~second_is_in}};
         port_split_out  <= split_latch;
         port_split_oe   <= split_data_out;
         group_a_mode    <= mode_a;
         group_b_mode    <= mode_b;
      end
   end
endmodule

/* File: ppio_core_props.sv */
/*
 Port-level checker for ppio_core.
 Assumes a bind to ppio_core and a single clock domain.
*/
`timescale 1ns/1ns
module ppio_core_props
   import ppio_pkg::*;
(
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       chip_sel_n,
   input wire logic       rd_n,
   input wire logic [1:0] port_select_addr,
   input wire logic       host_data_oe,
   input wire logic [7:0] port_first_out,
   input wire logic [7:0] port_first_oe,
   input wire logic [7:0] port_second_oe,
   input wire logic [7:0] port_split_out,
   input wire logic [7:0] port_split_oe,
   input wire logic [1:0] group_a_mode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   a_reset_inputs: assert property (
      $fell(srst) |-> !host_data_oe && (port_first_oe | port_second_oe
      | port_split_oe) == 8'h00) else $error("port driven after reset");
   a_cs_float: assert property (
      chip_sel_n [*5] |-> !host_data_oe) else $error("bus driven, cs high");
   a_cs_hold: assert property (
      chip_sel_n [*6] |-> $stable(port_first_out) && $stable(group_a_mode)
      && $stable(port_split_out)) else $error("state moved, cs high");
   a_rd_idle: assert property (
      rd_n [*5] |-> !host_data_oe) else $error("bus driven without read");
   a_read_answer: assert property (
      (!rd_n && !chip_sel_n && port_select_addr != ADDR_CONFIG) [*5]
      |-> host_data_oe) else $error("read not answered");
   a_cfg_noread: assert property (
      (port_select_addr == ADDR_CONFIG) [*3] |-> !host_data_oe)
      else $error("config address drove bus");
   a_basic_dirs: assert property (
      group_a_mode == MODE_BASIC |-> port_first_oe inside {8'h00, 8'hff}
      && port_split_oe[7:4] inside {4'h0, 4'hf}) else $error("mixed dir");
   a_bidir_drive: assert property (
      group_a_mode[1] |-> port_first_oe == 8'hff)
      else $error("bidir port not driven");
   a_split_one_bit: assert property (
      $changed(port_split_out) && $past(port_select_addr) == ADDR_CONFIG
      |-> port_split_out == 8'h00 ||
      $countones(port_split_out ^ $past(port_split_out)) == 1)
      else $error("split latch moved more than one bit");
endmodule

/* File: ppio_host_model.sv */
/*
 Host processor model for the parallel bus.
 Assumes the bench resolves the data bus from both drivers.
*/
`timescale 1ns/1ns
module ppio_host_model
(
   input  wire logic       clk,
   input  wire logic       bus_oe,
   output logic            chip_sel_n = 1'b1,
   output logic            rd_n = 1'b1,
   output logic            wr_n = 1'b1,
   output logic      [1:0] addr = 2'h0,
   output logic      [7:0] dq = 8'h5a
);
   // strobe low four cycles, address held past the edge
   task automatic wr(input logic [1:0] a, input logic [7:0] d,
                     input logic cs_n);
      @(posedge clk);
      chip_sel_n <= cs_n;
      addr <= a;
      dq <= d;
      wr_n <= 1'b0;
      repeat (4) @(posedge clk);
      wr_n <= 1'b1;
      repeat (4) @(posedge clk);
      chip_sel_n <= 1'b1;
      // Released bus shows the inverse, not a stale copy
      dq <= ~d;
      repeat (3) @(posedge clk);
   endtask
   // strobe held until the answer is seen or eight cycles pass
   task automatic rd(input logic [1:0] a, input logic cs_n,
                     input bit wt, output bit to);
      int n;
      @(posedge clk);
      chip_sel_n <= cs_n;
      addr <= a;
      rd_n <= 1'b0;
      for (n = 0; n < 8 && bus_oe !== 1'b1; n++)
         @(posedge clk);
      to = wt && bus_oe !== 1'b1;
      @(posedge clk);
      rd_n <= 1'b1;
      repeat (4) @(posedge clk);
      chip_sel_n <= 1'b1;
   endtask
endmodule

/* File: ppio_core_tb.sv */
/*
 Self-checking bench for ppio_core with a host model.
 Assumes pins resolve from latch, enable and outside levels.
*/
`timescale 1ns/1ns
module ppio_core_tb import ppio_pkg::*;;
   logic       clk = 1'b0;
   logic       srst = 1'b1;
   logic       cs_n, rd_n, wr_n, oe, oe_q = 1'b0, bmode, v;
   logic [1:0] adr, amode;
   logic [7:0] hdq, dout, fo, foe, so, soe, co, coe, w;
   logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] lat [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] msk [3] = '{8'h00, 8'h00, 8'h00};
   logic [7:0] expq [$];
   int         error_cnt = 0, samples_checked = 0, seed = 32'h34c6;
   bit         to;
   always #50 clk = ~clk;
   ppio_host_model u_host (.clk(clk), .bus_oe(oe), .chip_sel_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .addr(adr), .dq(hdq));
   ppio_core dut (.clk(clk), .srst(srst), .chip_sel_n(cs_n), .rd_n(rd_n),
      .wr_n(wr_n), .port_select_addr(adr), .host_data_in(oe ? dout : hdq),
      .host_data_out(dout), .host_data_oe(oe),
      .port_first_in(foe & fo | ~foe & ext[0]), .port_first_out(fo),
      .port_first_oe(foe), .port_second_in(soe & so | ~soe & ext[1]),
      .port_second_out(so), .port_second_oe(soe),
      .port_split_in(coe & co | ~coe & ext[2]), .port_split_out(co),
      .port_split_oe(coe), .group_a_mode(amode), .group_b_mode(bmode));
   task automatic conclude();
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Model follows every word written to the config address
   task automatic cfg(input logic [7:0] c);
      u_host.wr(ADDR_CONFIG, c, 1'b0);
      if (c[7]) begin
         lat[0] = 8'h00;
         lat[2] = 8'h00;
         msk[0] = c[4] ? 8'h00 : 8'hff;
         msk[1] = c[1] ? 8'h00 : 8'hff;
         msk[2] = {c[3] ? 4'h0 : 4'hf, c[0] ? 4'h0 : 4'hf};
      end else
         lat[2][c[3:1]] = c[0];
   endtask
   task automatic rdc(input int a);
      expq.push_back(msk[a] & lat[a] | ~msk[a] & ext[a]);
      u_host.rd(a[1:0], 1'b0, 1'b1, to);
      if (to) begin
         error_cnt++;
         $display("ERROR %0t read oe %h exp %h", $time, oe, 1'b1);
         conclude();
      end
   endtask
   always @(posedge clk) begin
      oe_q <= oe;
      if (oe && !oe_q) begin
         if (expq.size() > 0)
            chk(dout, expq.pop_front());
         else begin
            error_cnt++;
            $display("ERROR %0t drive %h exp %h", $time, oe, 1'b0);
         end
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk(foe | soe | coe | {6'h0, amode}, 8'h00);
      for (int i = 0; i < 3; i++) rdc(i);
      for (int m = 0; m < 16; m++) begin
         foreach (ext[i]) ext[i] <= 8'($random(seed));
         cfg({3'h4, m[3:2], 1'b0, m[1:0]});
         chk(foe, msk[0]);
         chk(soe, msk[1]);
         chk(coe, msk[2]);
         for (int i = 0; i < 3; i++) rdc(i);
         for (int i = 0; i < 3; i++) begin
            w = 8'($random(seed));
            u_host.wr(i[1:0], w, 1'b0);
            lat[i] = w;
         end
         for (int i = 0; i < 3; i++) rdc(i);
      end
      cfg(8'h80);
      for (int b = 0; b < 8; b++) begin
         v = 1'($random(seed));
         cfg({4'h0, b[2:0], v});
         rdc(2);
      end
      u_host.wr(ADDR_SPLIT, ~lat[2], 1'b1);
      u_host.rd(ADDR_FIRST, 1'b1, 1'b0, to);
      u_host.rd(ADDR_CONFIG, 1'b0, 1'b0, to);
      rdc(2);
      cfg(8'hc0);
      chk({foe[5:0], amode}, 8'hfe);
      chk(coe & 8'hf8, 8'h00);
      cfg(8'ha6);
      chk({amode, 5'h0, bmode}, 8'h41);
      chk(coe & 8'h07, 8'h00);
      // Mid-run reset while ports drive and second latch is loaded
      srst <= 1'b1;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk(foe | soe | coe | {5'h0, bmode, amode}, 8'h00);
      lat = '{8'h00, 8'h00, 8'h00};
      cfg(8'h80);
      rdc(1);
      conclude();
   end
endmodule
bind ppio_core ppio_core_props u_props (.clk(clk), .srst(srst),
   .chip_sel_n(chip_sel_n), .rd_n(rd_n),
   .port_select_addr(port_select_addr), .host_data_oe(host_data_oe),
   .port_first_out(port_first_out), .port_first_oe(port_first_oe),
   .port_second_oe(port_second_oe), .port_split_out(port_split_out),
   .port_split_oe(port_split_oe), .group_a_mode(group_a_mode));
